// >>> rtl/iobx_decode.sv
// Instruction word decoder for the five supported operations
module iobx_decode
   import iobx_pkg::*;
(
   input  wire logic [INSN_W-1:0] i_insn,
   output iobx_dec_t              o_dec
);
   wire logic is_inc      = (i_insn[13:8] == OPC_INC);
   wire logic is_inc_skip = (i_insn[13:8] == OPC_INC_SKIP);
   wire logic is_or_reg   = (i_insn[13:8] == OPC_OR_REG);
   wire logic is_or_lit   = (i_insn[13:8] == OPC_OR_LIT);
   wire logic is_jump     = (i_insn[13:11] == OPC_JUMP);

   // Priority is irrelevant: encodings do not overlap
   assign o_dec.op = is_inc      ? IOBX_OP_INC      :
                     is_inc_skip ? IOBX_OP_INC_SKIP :
                     is_or_reg   ? IOBX_OP_OR_REG   :
                     is_or_lit   ? IOBX_OP_OR_LIT   :
                     is_jump     ? IOBX_OP_JUMP     : IOBX_OP_NONE;
   assign o_dec.dest_file = i_insn[DEST_BIT];
   assign o_dec.faddr     = i_insn[FADDR_W-1:0];
   assign o_dec.literal   = i_insn[DATA_W-1:0];
   assign o_dec.target    = i_insn[IMM_W-1:0];
endmodule

// >>> rtl/iobx_exec.sv
// Execution stage: increment, increment-skip, jump and OR operations
// One instruction word is offered per cycle on i_insn, qualified by
// i_insn_valid. It is decoded and executed in that same cycle and every
// result lands in a flip-flop at the taking edge, so the new accumulator,
// zero flag, program counter and file write show one cycle later.
//
// A taken skip or a jump raises o_flush for the following word. That word
// was already fetched, so the program counter counts it, but it is
// otherwise thrown away and changes no state.
//
// Words that none of the five operations decode behave as a no-operation
// and only step the program counter.
//
// The register file lives outside: its read is combinational on
// o_file_raddr within the cycle, and its write is a registered request
// whose enable stands until the next clock-enabled edge.
//
// Limitation: a file write issued at one edge is not yet in the file
// during the next cycle's read unless the file forwards it; the caller
// must bypass or stall when a word reads what the previous one wrote.
//
// While i_ce is low every register holds; the synchronous reset still
// acts, so a frozen core can be brought back to its start state.
module iobx_exec
   import iobx_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_reset,
   input  wire logic              i_ce,
   input  wire logic              i_insn_valid,
   input  wire logic [INSN_W-1:0] i_insn,
   input  wire logic [DATA_W-1:0] i_file_rdata,
   input  wire logic [DATA_W-1:0] i_upper_latch,
   output logic [FADDR_W-1:0]     o_file_raddr,
   output iobx_fwr_t              o_file_wr,
   output logic [DATA_W-1:0]      o_accum,
   output logic                   o_zero_flag,
   output logic [PC_W-1:0]        o_pc,
   output logic                   o_flush
);

   // Run executes words; flush turns the next offered word into a no-op
   typedef enum logic [0:0] {
      IOBX_RUN,
      IOBX_FLUSH
   } iobx_state_t;

   // Decoded fields of the word on offer
   iobx_dec_t              dec;

   // Architectural state and the values it takes at the next edge
   iobx_state_t            state_reg;
   iobx_state_t            state_next;
   logic [DATA_W-1:0]      accum_reg;
   logic [DATA_W-1:0]      accum_next;
   logic                   zero_reg;
   logic                   zero_next;
   logic [PC_W-1:0]        pc_reg;
   logic [PC_W-1:0]        pc_next;
   iobx_fwr_t              fwr_reg;
   iobx_fwr_t              fwr_next;

   // Issue strobes: a common one, one per supported operation, and both increments merged
   wire logic              exec;
   wire logic              op_inc;
   wire logic              op_inc_skip;
   wire logic              op_jump;
   wire logic              op_or_lit;
   wire logic              op_or_reg;
   wire logic              any_inc;

   // Datapath results
   wire logic [DATA_W-1:0] inc_sum;
   wire logic [DATA_W-1:0] or_reg;
   wire logic [DATA_W-1:0] or_lit;
   wire logic [DATA_W-1:0] result;
   wire logic              result_zero;

   // Routing and sequencing decisions
   wire logic              to_file;
   wire logic              to_accum;
   wire logic              sets_zero;
   wire logic              skip_hit;
   wire logic              flush_req;
   wire logic              flush_done;
   wire logic [PC_W-1:0]   pc_step;
   wire logic [PC_W-1:0]   pc_jump;

   // Field extraction is kept in its own module so that further
   // operations can be added to the decoder without touching this stage
   iobx_decode u_decode (
      .i_insn (i_insn),
      .o_dec  (dec)
   );

   // The file read address comes straight from the instruction
   assign o_file_raddr = dec.faddr;

   // A word executes only outside a flush cycle; the clock enable is
   // applied at the registers, so these strobes may rise while frozen
   assign exec        = i_insn_valid && (state_reg == IOBX_RUN);
   assign op_inc      = exec && (dec.op == IOBX_OP_INC);
   assign op_inc_skip = exec && (dec.op == IOBX_OP_INC_SKIP);
   assign op_jump     = exec && (dec.op == IOBX_OP_JUMP);
   assign op_or_lit   = exec && (dec.op == IOBX_OP_OR_LIT);
   assign op_or_reg   = exec && (dec.op == IOBX_OP_OR_REG);
   assign any_inc     = op_inc || op_inc_skip;

   // Eight-bit increment: the carry out is dropped on purpose, so FF
   // wraps to 00, which is exactly what the skip test looks for
   assign inc_sum = i_file_rdata + 8'h01;

   // Bitwise OR, one slice per data bit
   generate
      for (genvar bi = 0; bi < DATA_W; bi++) begin : g_or_bit
         assign or_reg[bi] = accum_reg[bi] | i_file_rdata[bi];
         assign or_lit[bi] = accum_reg[bi] | dec.literal[bi];
      end
   endgenerate

   // One shared result bus; select order is free since at most one
   // operation strobe is high in any cycle
   assign result      = any_inc   ? inc_sum :
                        op_or_reg ? or_reg  : or_lit;
   assign result_zero = (result == 8'h00);

   // Destination routing: d picks the file or the accumulator for the
   // register forms, while OR-literal always lands in the accumulator
   assign to_file  = (any_inc || op_or_reg) && dec.dest_file;
   assign to_accum = ((any_inc || op_or_reg) && !dec.dest_file)
                     || op_or_lit;

   // The accumulator keeps its value unless an operation routes to it
   assign accum_next = to_accum ? result : accum_reg;

   // Zero flag: only the plain increment and the ORs touch it; the
   // skip and the jump must leave it exactly as it was
   assign sets_zero = op_inc || op_or_lit || op_or_reg;
   assign zero_next = sets_zero ? result_zero : zero_reg;

   // A skip whose increment wraps to 00 and a jump both discard the word that is already fetched
   assign skip_hit  = op_inc_skip && result_zero;
   assign flush_req = skip_hit || op_jump;

   // The discarded slot is used up by the next valid word; an idle
   // cycle in between leaves the flush pending
   assign flush_done = (state_reg == IOBX_FLUSH) && i_insn_valid;
   assign state_next = flush_req  ? IOBX_FLUSH :
                       flush_done ? IOBX_RUN   : state_reg;

   // Program counter: the jump target replaces the count; every other
   // valid word, discarded ones included, steps it by one
   assign pc_jump = {i_upper_latch[LATCH_HI:LATCH_LO], dec.target};
   assign pc_step = pc_reg + 13'h0001;
   assign pc_next = op_jump      ? pc_jump :
                    i_insn_valid ? pc_step : pc_reg;

   // File write request, registered so the data leaves a flip-flop;
   // address and data ride along but only count while we is high
   assign fwr_next.we   = to_file;
   assign fwr_next.addr = dec.faddr;
   assign fwr_next.data = result;

   // Sequencer state; reset acts even while the clock enable is low
   // so a frozen core can still be restarted
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_reg <= IOBX_RUN;
      end else if (i_ce) begin
         state_reg <= state_next;
      end
   end

   // Accumulator, held while the clock enable is low; reset clears it
   // so the first OR sees a known operand
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         accum_reg <= ACCUM_RESET;
      end else if (i_ce) begin
         accum_reg <= accum_next;
      end
   end

   // Zero flag, cleared by reset; only the operations that set
   // sets_zero change it, through zero_next
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         zero_reg <= 1'h0;
      end else if (i_ce) begin
         zero_reg <= zero_next;
      end
   end

   // Program counter; reset starts fetching from the reset address and
   // the count wraps at the top of the thirteen-bit space
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         pc_reg <= PC_RESET;
      end else if (i_ce) begin
         pc_reg <= pc_next;
      end
   end

   // File write request; reset drops any pending write so that the file
   // is not corrupted by a word that was still in flight
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         fwr_reg <= '0;
      end else if (i_ce) begin
         fwr_reg <= fwr_next;
      end
   end

   // Outputs all come from flip-flops except o_file_raddr, which is combinational
   assign o_accum     = accum_reg;
   assign o_zero_flag = zero_reg;
   assign o_pc        = pc_reg;
   assign o_file_wr   = fwr_reg;
   assign o_flush     = (state_reg == IOBX_FLUSH);
endmodule

// >>> rtl/iobx_pkg.sv
// Package: opcode fields, encodings, operation type and field structs for the execution block
package iobx_pkg;
   localparam int unsigned DATA_W    = 8;
   localparam int unsigned FADDR_W   = 7;
   localparam int unsigned PC_W      = 13;
   localparam int unsigned IMM_W     = 11;
   localparam int unsigned INSN_W    = 14;
   localparam int unsigned LATCH_HI  = 4;
   localparam int unsigned LATCH_LO  = 3;
   // Instruction field positions
   localparam int unsigned DEST_BIT  = 7;
   // Opcode encodings, matched on the upper bits of the instruction word
   localparam logic [5:0] OPC_INC      = 6'h0A;
   localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
   localparam logic [5:0] OPC_OR_REG   = 6'h04;
   localparam logic [5:0] OPC_OR_LIT   = 6'h38;
   localparam logic [2:0] OPC_JUMP     = 3'h5;
   localparam logic [PC_W-1:0]   PC_RESET   = 13'h0000;
   localparam logic [DATA_W-1:0] ACCUM_RESET = 8'h00;

   typedef enum logic [2:0] {
      IOBX_OP_NONE,
      IOBX_OP_INC,
      IOBX_OP_INC_SKIP,
      IOBX_OP_JUMP,
      IOBX_OP_OR_LIT,
      IOBX_OP_OR_REG
   } iobx_op_t;

   // Decoded instruction fields
   typedef struct packed {
      iobx_op_t               op;
      logic                   dest_file;
      logic [FADDR_W-1:0]     faddr;
      logic [DATA_W-1:0]      literal;
      logic [IMM_W-1:0]       target;
   } iobx_dec_t;

   // Register file write request
   typedef struct packed {
      logic                   we;
      logic [FADDR_W-1:0]     addr;
      logic [DATA_W-1:0]      data;
   } iobx_fwr_t;
endpackage

// >>> testbench/iobx_exec_sva.sv
// Checker for the execution block ports
module iobx_exec_sva import iobx_pkg::*; (
   input wire logic        i_clk, i_reset, i_ce, i_insn_valid,
   input wire logic [13:0] i_insn,
   input wire logic [7:0]  i_file_rdata, i_upper_latch, o_accum,
   input wire iobx_fwr_t   o_file_wr,
   input wire logic        o_zero_flag, o_flush,
   input wire logic [12:0] o_pc
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // Causes at the taking edge; outputs are judged one edge later
   wire       tk = i_ce && i_insn_valid && !o_flush;
   wire [5:0] op = i_insn[13:8];
   wire       d = i_insn[DEST_BIT];
   wire       inc = tk && (op == OPC_INC || op == OPC_INC_SKIP);
   wire [7:0] sum = i_file_rdata + 8'h01;
   wire [7:0] res = op == OPC_OR_LIT ? o_accum | i_insn[7:0] :
                    op == OPC_OR_REG ? o_accum | i_file_rdata : sum;
   sequence s_jmp;
      tk && i_insn[13:11] == OPC_JUMP;
   endsequence
   sequence s_skz;
      tk && op == OPC_INC_SKIP && sum == 8'h00;
   endsequence
   a_jump_target: assert property (s_jmp |=>
      o_pc == {$past(i_upper_latch[4:3]), $past(i_insn[10:0])})
      else $error("bad jump target");
   a_jump_slot: assert property (s_jmp |=>
      o_flush && $stable(o_zero_flag)) else $error("bad jump slot");
   a_skip_zero: assert property (s_skz |=>
      o_flush && $stable(o_zero_flag)) else $error("bad skip");
   a_inc_accum: assert property (inc && !d |=>
      o_accum == $past(sum)) else $error("bad inc accum");
   a_inc_file: assert property (inc && d |=>
      o_file_wr == {1'b1, $past(i_insn[6:0]), $past(sum)})
      else $error("bad inc write");
   a_or_lit: assert property (tk && op == OPC_OR_LIT |=>
      o_accum == $past(res)) else $error("bad or literal");
   a_or_reg: assert property (tk && op == OPC_OR_REG && !d |=>
      o_accum == $past(res)) else $error("bad or reg");
   a_zero_flag: assert property (tk && (op == OPC_INC ||
      op == OPC_OR_LIT || op == OPC_OR_REG) |=>
      o_zero_flag == ($past(res) == 8'h00) && !o_flush)
      else $error("bad zero");
   a_or_file: assert property (tk && op == OPC_OR_REG && d |=>
      o_file_wr == {1'h1, $past(i_insn[6:0]), $past(res)})
      else $error("bad or write");
   a_flush_drop: assert property (o_flush && i_ce && i_insn_valid |=>
      !o_flush && !o_file_wr.we && $stable(o_accum)
      && $stable(o_zero_flag)) else $error("bad discard");
endmodule
bind iobx_exec iobx_exec_sva iobx_exec_sva_inst (.i_clk, .i_reset, .i_ce,
   .i_insn_valid, .i_insn, .i_file_rdata, .i_upper_latch, .o_accum,
   .o_file_wr, .o_zero_flag, .o_flush, .o_pc);

// >>> testbench/iobx_exec_tb.sv
// Random bench with reference model for the execution block
module iobx_exec_tb import iobx_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clk = 0, i_reset = 1, i_ce = 0, i_insn_valid = 0;
   logic [13:0] i_insn = '0, ins;
   logic [7:0]  i_file_rdata = '0, i_upper_latch = '0, o_accum, am = '0, s;
   logic [6:0]  o_file_raddr;
   logic [12:0] o_pc, pm = '0;
   logic        o_zero_flag, o_flush, zm = 0, fl = 0, fc = 1, ce, vld;
   logic        rst = 0;
   logic [31:0] r;
   iobx_fwr_t   o_file_wr, fm = '0;
   int          err_count = 0, compares = 0, op;
   iobx_exec iobx_exec_inst (.i_clk, .i_reset, .i_ce, .i_insn_valid, .i_insn,
      .i_file_rdata, .i_upper_latch, .o_file_raddr, .o_file_wr, .o_accum,
      .o_zero_flag, .o_pc, .o_flush);
   task automatic chk(string n, logic [15:0] v, e);
      compares++;
      if (v !== e) begin
         err_count++;
         $display("CHECK FAILED %s exp %h seen %h", n, e, v);
      end
   endtask
   task automatic conclude;
      $display("mismatches %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Expected eight-bit result of the word on offer
   function automatic logic [7:0] calc(int o, logic [13:0] w,
      logic [7:0] a, f);
      return o < 2 ? f + 8'h01 : o == 3 ? a | w[7:0] : a | f;
   endfunction
   // Expected state after the coming edge; a frozen edge changes nothing
   task automatic step;
      // A reset edge returns everything to its start values
      if (rst) begin
         am = '0;
         zm = 0;
         pm = '0;
         fm = '0;
         fl = 0;
         fc = 1;
         return;
      end
      fc = ce;
      if (!ce) return;
      fm.we = 1'h0;
      if (!vld) return;
      pm++;
      if (fl) begin
         fl = 0;
         return;
      end
      if (op == 5) return; // Undecoded word: only the count moves
      s = calc(op, ins, am, i_file_rdata);
      if (op == 2) begin
         pm = {i_upper_latch[4:3], ins[10:0]};
         fl = 1;
      end else if (op == 3 || !ins[7]) am = s;
      else fm = '{1'h1, ins[6:0], s};
      if (op == 1 && s == 8'h00) fl = 1;
      if (op != 1 && op != 2) zm = s == 8'h00;
   endtask
   initial forever #20 i_clk = ~i_clk;
   // Random words with idle and frozen cycles; FF read data and zero literals are biased in
   initial begin
      r = $urandom(32'hC149946F);
      repeat (12) @(posedge i_clk);
      i_reset <= 1'h0;
      for (int k = 0; k < 600; k++) begin
         @(posedge i_clk);
         // One mid-run reset checks the return to the start values
         rst = k == 300;
         i_reset <= rst;
         r = $urandom;
         op = $urandom_range(5);
         ce = r[30:28] != 3'h0;
         vld = r[27:25] != 3'h0;
         ins = op == 0 ? {OPC_INC, r[7:0]} : op == 1 ? {OPC_INC_SKIP, r[7:0]}
            : op == 2 ? {OPC_JUMP, r[10:0]}
            : op == 3 ? {OPC_OR_LIT, r[7:0] & {8{|r[24:22]}}}
            : op == 4 ? {OPC_OR_REG, r[7:0]} : {6'h00, r[7:0]};
         i_insn <= ins;
         i_ce <= ce;
         i_insn_valid <= vld;
         i_file_rdata <= r[21:19] == 3'h0 ? 8'hFF : r[15:8];
         i_upper_latch <= r[23:16];
         #1;
         chk("accum", o_accum, am);
         chk("zero", o_zero_flag, zm);
         chk("pc", o_pc, pm);
         chk("flush", o_flush, fl);
         chk("raddr", o_file_raddr, ins[6:0]);
         if (fc) chk("we", o_file_wr.we, fm.we);
         if (fc && fm.we) chk("fwr", o_file_wr, fm);
         step();
      end
      conclude();
   end
endmodule
